// [hdl/smi_consts.svh]
`ifndef SMI_CONSTS_SVH
`define SMI_CONSTS_SVH
`define SMI_NUM_REGS 32
`define SMI_DATA_W 16
`define SMI_PAGE_REG 5'h1f
`define SMI_MMD_CTRL_REG 5'h0d
`define SMI_MMD_DATA_REG 5'h0e
`define SMI_IRQ_MASK_REG 5'h19
`define SMI_IRQ_STAT_REG 5'h1a
`define SMI_IRQ_PIN_EN_BIT 15
`define SMI_IRQ_EVT_BIT 9
`define SMI_OP_READ 2'h2
`define SMI_OP_WRITE 2'h1
`define SMI_START 2'h1
`define SMI_EXT_PAGES 4
`define SMI_MMD_DEPTH 16
`endif

// [hdl/smi_pkg.sv]
package smi_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_HEAD = 3'h3,
        ST_TA = 3'h2,
        ST_DATA = 3'h6,
        ST_WAIT = 3'h7
    } smi_state_t;
    typedef struct packed {
        logic [4:0] regAddr;
        logic [15:0] data;
    } reg_write_t;
endpackage

// [hdl/phy_serial_management_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "smi_consts.svh"
module phy_serial_management_port
    import smi_pkg::*;
#(
    parameter int EXT_PAGES = `SMI_EXT_PAGES,
    parameter int MMD_DEPTH = `SMI_MMD_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mgmtClk,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic [4:0] phyAddr,
    input wire logic irqEvent,
    input wire logic lowPower,
    output logic mgmtIrqOut,
    output logic mgmtIrqOe
);
    localparam int PW = $clog2(EXT_PAGES);
    localparam int MW = $clog2(MMD_DEPTH);

    initial begin
        if (EXT_PAGES < 2 || MMD_DEPTH < 2) begin
            $error("EXT_PAGES and MMD_DEPTH must be at least 2");
        end
    end

    function automatic logic isDirect(input logic [4:0] a);
        return a == `SMI_PAGE_REG || a == `SMI_MMD_CTRL_REG ||
            a == `SMI_MMD_DATA_REG || a == `SMI_IRQ_STAT_REG;
    endfunction

    // Link-clock domain frame engine; lowPower is deliberately unused
    smi_state_t state;
    logic [5:0] cnt;
    logic [11:0] head;
    logic [15:0] shift;
    logic [15:0] rdValue;
    logic [4:0] rdAddr;
    logic prevOne;
    logic [4:0] paSync0;
    logic [4:0] paSync1;

    // Station address strap into the link domain
    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) begin
            paSync0 <= 5'h00;
            paSync1 <= 5'h00;
        end else begin
            paSync0 <= phyAddr;
            paSync1 <= paSync0;
        end
    end

    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
            head <= 12'h000;
            shift <= 16'h0000;
            prevOne <= 1'b0;
            rdAddr <= 5'h00;
        end else begin
            prevOne <= mdioIn;
            unique case (state)
                ST_IDLE: begin
                    if (!mdioIn) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (mdioIn) begin
                        state <= ST_HEAD;
                        cnt <= 6'h00;
                    end else begin
                        state <= ST_WAIT;
                    end
                end
                ST_HEAD: begin
                    head <= {head[10:0], mdioIn};
                    cnt <= cnt + 6'h01;
                    if (cnt == 6'h01 && {head[0], mdioIn} != `SMI_OP_READ
                        && {head[0], mdioIn} != `SMI_OP_WRITE) begin
                        state <= ST_WAIT;
                    end else if (cnt == 6'h0b) begin
                        if (head[8:4] != paSync1) begin
                            state <= ST_WAIT;
                        end else begin
                            state <= ST_TA;
                            cnt <= 6'h00;
                            rdAddr <= {head[3:0], mdioIn};
                        end
                    end
                end
                ST_TA: begin
                    cnt <= cnt + 6'h01;
                    if (cnt == 6'h01) begin
                        state <= ST_DATA;
                        cnt <= 6'h00;
                        shift <= rdValue;
                    end
                end
                ST_DATA: begin
                    shift <= {shift[14:0], mdioIn};
                    cnt <= cnt + 6'h01;
                    if (cnt == 6'h0f) begin
                        state <= ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    if (mdioIn && prevOne) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Data line drive, launched on the rising link edge
    logic isRead;
    assign isRead = head[11:10] == `SMI_OP_READ;
    logic isWrite;
    assign isWrite = head[11:10] == `SMI_OP_WRITE;
    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) begin
            mdioOe <= 1'b0;
            mdioOut <= 1'b1;
        end else if (state == ST_TA && cnt == 6'h00 && isRead) begin
            mdioOe <= 1'b1;
            mdioOut <= 1'b0;
        end else if (state == ST_TA && cnt == 6'h01 && isRead) begin
            mdioOe <= 1'b1;
            mdioOut <= rdValue[15];
        end else if (state == ST_DATA && isRead && cnt != 6'h0f) begin
            mdioOe <= 1'b1;
            mdioOut <= shift[14];
        end else begin
            mdioOe <= 1'b0;
            mdioOut <= 1'b1;
        end
    end

    // Completed write, applied on the last data edge
    reg_write_t wrWord;
    logic wrStb;
    assign wrWord = {head[4:0], shift[14:0], mdioIn};
    assign wrStb = state == ST_DATA && cnt == 6'h0f && isWrite;

    // Register storage
    logic [15:0] regs [`SMI_NUM_REGS];
    logic [15:0] pageRegs [EXT_PAGES][`SMI_NUM_REGS];
    logic [15:0] mmdRegs [MMD_DEPTH];
    logic [15:0] page;
    logic [15:0] mmdCtrl;
    logic [15:0] mmdAddr;
    logic [PW-1:0] pIdx;
    assign pIdx = page[PW-1:0];
    logic [MW-1:0] mIdx;
    assign mIdx = mmdAddr[MW-1:0];
    logic isAddrMode;
    assign isAddrMode = mmdCtrl[15:14] == 2'h0;

    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `SMI_NUM_REGS; i++) begin
                regs[i] <= 16'h0000;
                for (int p = 0; p < EXT_PAGES; p++) begin
                    pageRegs[p][i] <= 16'h0000;
                end
            end
        end else if (wrStb && !isDirect(wrWord.regAddr)) begin
            if (page == 16'h0000) begin
                regs[wrWord.regAddr] <= wrWord.data;
            end else begin
                pageRegs[pIdx][wrWord.regAddr] <= wrWord.data;
            end
        end
    end

    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) begin
            page <= 16'h0000;
        end else if (wrStb && wrWord.regAddr == `SMI_PAGE_REG) begin
            page <= wrWord.data;
        end
    end

    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) begin
            mmdCtrl <= 16'h0000;
            mmdAddr <= 16'h0000;
            for (int i = 0; i < MMD_DEPTH; i++) begin
                mmdRegs[i] <= 16'h0000;
            end
        end else if (wrStb && wrWord.regAddr == `SMI_MMD_CTRL_REG) begin
            mmdCtrl <= wrWord.data;
        end else if (wrStb && wrWord.regAddr == `SMI_MMD_DATA_REG) begin
            if (isAddrMode) begin
                mmdAddr <= wrWord.data;
            end else begin
                mmdRegs[mIdx] <= wrWord.data;
            end
        end
    end

    // Interrupt status; set wins over read-clear
    logic [2:0] evtSync;
    logic pending;
    logic clrTgl;
    logic [2:0] clrSync;
    logic [1:0] enSync;
    logic [1:0] pendSync;
    logic pinEn;
    assign pinEn = regs[`SMI_IRQ_MASK_REG][`SMI_IRQ_PIN_EN_BIT];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evtSync <= 3'h0;
            clrSync <= 3'h0;
            enSync <= 2'h0;
        end else begin
            evtSync <= {evtSync[1:0], irqEvent};
            clrSync <= {clrSync[1:0], clrTgl};
            enSync <= {enSync[0], pinEn};
        end
    end

    // Pending flag into the link domain, clear request out of it
    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) begin
            pendSync <= 2'h0;
            clrTgl <= 1'b0;
        end else begin
            pendSync <= {pendSync[0], pending};
            if (state == ST_TA && cnt == 6'h00 && isRead &&
                rdAddr == `SMI_IRQ_STAT_REG && page == 16'h0000) begin
                clrTgl <= ~clrTgl;
            end
        end
    end
    logic evtRise;
    assign evtRise = evtSync[1] & ~evtSync[2];
    logic clrPending;
    assign clrPending = clrSync[2] ^ clrSync[1];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
        end else if (evtRise) begin
            pending <= 1'b1;
        end else if (clrPending) begin
            pending <= 1'b0;
        end
    end

    // Read data, loaded into the shifter as the turnaround ends
    always_comb begin
        if (rdAddr == `SMI_PAGE_REG) begin
            rdValue = page;
        end else if (rdAddr == `SMI_MMD_CTRL_REG) begin
            rdValue = mmdCtrl;
        end else if (rdAddr == `SMI_MMD_DATA_REG) begin
            rdValue = isAddrMode ? mmdAddr : mmdRegs[mIdx];
        end else if (rdAddr == `SMI_IRQ_STAT_REG && page == 16'h0000) begin
            rdValue = 16'h0000;
            rdValue[`SMI_IRQ_EVT_BIT] = pendSync[1];
        end else if (page == 16'h0000) begin
            rdValue = regs[rdAddr];
        end else begin
            rdValue = pageRegs[pIdx][rdAddr];
        end
    end
    // Open-drain interrupt pin
    logic irqOn;
    assign irqOn = pending && enSync[1];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mgmtIrqOe <= 1'b0;
        end else begin
            mgmtIrqOe <= irqOn;
        end
    end
    assign mgmtIrqOut = 1'b0;
endmodule // phy_serial_management_port
`default_nettype wire

// [tb/phy_smi_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_smi_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mgmtClk,
    input wire logic mdioIn,
    input wire logic mdioOut,
    input wire logic mdioOe,
    input wire logic [4:0] phyAddr,
    input wire logic irqEvent,
    input wire logic lowPower,
    input wire logic mgmtIrqOut,
    input wire logic mgmtIrqOe
);
    logic [14:0] hist;
    logic [3:0] sinceEvt;
    logic evtQ;
    // Last fifteen line bits
    always_ff @(posedge mgmtClk or posedge rst) begin
        if (rst) hist <= '1;
        else hist <= {hist[13:0], mdioIn};
    end
    // Ref cycles since the last event rise
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evtQ <= 1'b0;
            sinceEvt <= 4'hf;
        end else begin
            evtQ <= irqEvent;
            if (irqEvent && !evtQ) sinceEvt <= 4'h0;
            else if (sinceEvt != 4'hf) sinceEvt <= sinceEvt + 4'h1;
        end
    end
    AST_START: assert property (@(posedge mgmtClk) disable iff (rst)
        $rose(mdioOe) |-> hist[14:13] == 2'b01) else $error("no start");
    AST_OPCODE: assert property (@(posedge mgmtClk) disable iff (rst)
        $rose(mdioOe) |-> hist[12:11] == 2'b10) else $error("not a read");
    AST_ADDR: assert property (@(posedge mgmtClk) disable iff (rst)
        $rose(mdioOe) |-> hist[10:6] == phyAddr) else $error("foreign");
    AST_TA_Z: assert property (@(posedge mgmtClk) disable iff (rst)
        $rose(mdioOe) |-> hist[0]) else $error("first turnaround driven");
    AST_TA_ZERO: assert property (@(posedge mgmtClk) disable iff (rst)
        $rose(mdioOe) |-> !mdioOut) else $error("turnaround not zero");
    AST_READ_LEN: assert property (@(posedge mgmtClk) disable iff (rst)
        $rose(mdioOe) |-> mdioOe[*8] ##1 mdioOe[*8] ##1 mdioOe ##1 !mdioOe)
        else $error("read drive length");
    AST_IDLE: assert property (@(posedge mgmtClk) disable iff (rst)
        $fell(mdioOe) |-> (!mdioOe)[*8]) else $error("driven while idle");
    AST_IRQ_OUT: assert property (@(posedge ref_clk) disable iff (rst)
        mgmtIrqOut == 1'b0) else $error("interrupt driven high");
    AST_IRQ_CAUSE: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(mgmtIrqOe) |-> sinceEvt < 4'hc) else $error("irq no event");
    cover property (@(posedge mgmtClk) disable iff (rst) $rose(mdioOe));
    cover property (@(posedge ref_clk) disable iff (rst) $rose(mgmtIrqOe));
    cover property (@(posedge ref_clk) disable iff (rst) $fell(mgmtIrqOe));
endmodule // phy_smi_checker
bind phy_serial_management_port phy_smi_checker u_chk (.ref_clk(ref_clk),
    .rst(rst), .mgmtClk(mgmtClk), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .phyAddr(phyAddr), .irqEvent(irqEvent),
    .lowPower(lowPower), .mgmtIrqOut(mgmtIrqOut), .mgmtIrqOe(mgmtIrqOe));
`default_nettype wire

// [tb/smi_station_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smi_station_model (
    output logic mgmtClk,
    output logic mgrOe,
    output logic mgrBit
);
    int halfNs = 40;
    initial begin
        mgmtClk = 1'b0;
        mgrOe = 1'b0;
        mgrBit = 1'b1;
    end
    // Bit set while clock low, sampled at rise
    task automatic bitOut(input logic b, input logic oe);
        mgrOe = oe;
        mgrBit = b;
        #(halfNs) mgmtClk = 1'b1;
        #(halfNs) mgmtClk = 1'b0;
    endtask
    // Clock stands still between frames
    task automatic frame(input int pre, input logic [1:0] st,
            input logic [1:0] op, input logic [4:0] pa,
            input logic [4:0] ra, input logic [15:0] d);
        logic [31:0] f;
        f = {st, op, pa, ra, 2'b10, d};
        repeat (pre) bitOut(1'b1, 1'b1);
        for (int i = 31; i >= 0; i--) bitOut(f[i], !(op == 2'b10 && i < 18));
        if (op == 2'b10) bitOut(1'b1, 1'b0);
    endtask
endmodule // smi_station_model
`default_nettype wire

// [tb/phy_serial_management_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_serial_management_port_tb import smi_pkg::*;;
    logic ref_clk, rst, mdioIn, mdioOut, mdioOe, irqEvent, lowPower;
    logic mgmtIrqOut, mgmtIrqOe, mgmtClk, mgrOe, mgrBit;
    logic [4:0] phyAddr;
    logic [4:0] ra[4] = '{5'h00, 5'h09, 5'h12, 5'h1e};
    logic [15:0] d[4];
    logic [15:0] expQ[$];
    logic [16:0] rdBits;
    int rdCnt, fails, n_tests, seed;
    assign mdioIn = mdioOe ? mdioOut : (mgrOe ? mgrBit : 1'b1);
    phy_serial_management_port u_dut (.ref_clk(ref_clk), .rst(rst),
        .mgmtClk(mgmtClk), .mdioIn(mdioIn), .mdioOut(mdioOut),
        .mdioOe(mdioOe), .phyAddr(phyAddr), .irqEvent(irqEvent),
        .lowPower(lowPower), .mgmtIrqOut(mgmtIrqOut), .mgmtIrqOe(mgmtIrqOe));
    smi_station_model u_mgr (.mgmtClk(mgmtClk), .mgrOe(mgrOe),
        .mgrBit(mgrBit));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = !ref_clk;
    end
    task automatic check(input string what, input logic [16:0] exp,
            input logic [16:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic checkPin(input logic exp);
        @(negedge ref_clk);
        check("irq pin", {16'h0, exp}, {16'h0, mgmtIrqOe});
    endtask
    task automatic end_sim();
        check("leftover reads", 17'h0, 17'(expQ.size()));
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge ref_clk) lowPower <= 1'($random(seed));
        u_mgr.frame(0, 2'b01, 2'b01, phyAddr, a, v);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        expQ.push_back(e);
        u_mgr.frame(1, 2'b01, 2'b10, phyAddr, a, 16'h0);
    endtask
    task automatic pulse();
        @(posedge ref_clk) irqEvent <= 1'b1;
        repeat (4) @(posedge ref_clk);
        irqEvent <= 1'b0;
        repeat (12) @(posedge ref_clk);
    endtask
    // Collects turnaround zero and sixteen data bits
    always @(negedge mgmtClk) begin
        if (mdioOe === 1'b1) begin
            rdBits = {rdBits[15:0], mdioIn};
            rdCnt++;
            if (rdCnt == 17)
                check("read", expQ.size() ? {1'b0, expQ.pop_front()} : 'x,
                    rdBits);
        end else rdCnt = 0;
    end
    initial begin
        #2000000;
        fails++;
        end_sim();
    end
    initial begin
        seed = 32'hb7c6;
        {fails, n_tests, rdCnt} = '0;
        rst = 1'b1;
        irqEvent = 1'b0;
        lowPower = 1'b0;
        phyAddr = 5'h0b;
        fork
            repeat (4) u_mgr.bitOut(1'b1, 1'b1);
        join_none
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        #7;
        repeat (2) u_mgr.bitOut(1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            d[i] = 16'($random(seed));
            wr(ra[i], d[i]);
        end
        for (int i = 0; i < 4; i++) rd(ra[i], d[i]);
        u_mgr.frame(0, 2'b00, 2'b01, 5'h0, 5'h0, 16'h0);
        u_mgr.frame(2, 2'b01, 2'b11, 5'h0, 5'h0, 16'h0);
        u_mgr.frame(2, 2'b01, 2'b00, 5'h0, 5'h0, 16'h0);
        u_mgr.frame(2, 2'b01, 2'b01, phyAddr ^ 5'h04, 5'h12, 16'h5555);
        u_mgr.frame(1, 2'b01, 2'b10, phyAddr ^ 5'h04, 5'h12, 16'h0);
        rd(5'h12, d[2]);
        wr(5'h1f, 16'h0001);
        wr(5'h05, d[0]);
        rd(5'h05, d[0]);
        rd(5'h1f, 16'h0001);
        wr(5'h1f, 16'h0000);
        rd(5'h05, 16'h0000);
        wr(5'h0d, 16'h0000);
        wr(5'h0e, 16'h0003);
        wr(5'h0d, 16'h4000);
        wr(5'h0e, d[1]);
        rd(5'h0e, d[1]);
        wr(5'h0d, 16'h0000);
        rd(5'h0e, 16'h0003);
        wr(5'h19, 16'h8000);
        pulse();
        checkPin(1'b1);
        rd(5'h1a, 16'h0200);
        repeat (8) @(posedge ref_clk);
        checkPin(1'b0);
        wr(5'h19, 16'h0000);
        pulse();
        checkPin(1'b0);
        rd(5'h1a, 16'h0200);
        rd(5'h1a, 16'h0000);
        repeat (8) @(posedge ref_clk);
        end_sim();
    end
endmodule // phy_serial_management_port_tb
`default_nettype wire
